// ===== hdl/adc_reset_startup_sequencer.v
// reset sources, ready edge, modulator wait and filter handover for the adc core
// Operation
// - three reset sources: power-on, pin, command
// - any reset restores defaults, then converts
// - rising ready edge; earlier spi traffic ignored
// - power-on delay then ready goes high
// - long pin low resets until released
// - frames are six words, completed fully
// - reset command latched only at frame end
// - latched reset command resets immediately
// - modulator needs external clock or oscillator
// - wait 256 plus 44 modulator periods
// - both filter paths fed at once
// - continuous mode: two fast samples, then sinc3 output
// - pin/command reset skips power-on delay
// - every reset selects external clock again
// - continuous data every oversampling ratio periods
// - continuous and chop modes, chop delay
// - three power modes in either mode
// - chop result averages opposite-polarity pair
`include "adc_start_regs.vh"
module adc_reset_startup_sequencer #(
  parameter POR_CYCLES  = `POR_DELAY_CYC,
  parameter RSL_CYCLES  = `RESET_LOW_CYC,
  parameter SW          = `SAMPLE_W
) (
  input  wire          ref_clk,
  input  wire          arst_n,
  input  wire          syncReset_n,
  input  wire          external_clock_in,
  input  wire          frameWordValid,
  input  wire [15:0]   frameWord,
  input  wire          frameAbort,
  input  wire          oscEnableSet,
  input  wire          chop_enable,
  input  wire [15:0]   oversampling_ratio,
  input  wire [15:0]   chopDelay,
  input  wire [1:0]    powerModeSet,
  input  wire          powerModeWrite,
  input  wire          modBit,
  input  wire          sampleReady,
  output reg           data_ready_n,
  output reg           spiEnable,
  output reg           clockSelInt,
  output reg  [1:0]    powerMode,
  output reg           fastPathSel,
  output reg           modRun,
  output reg           chopPolarity,
  output reg  [SW-1:0] sampleData,
  output reg           sampleValid,
  output reg           sampleFast
);
  localparam ST_POR  = 5'h01;
  localparam ST_RST  = 5'h02;
  localparam ST_CLK  = 5'h04;
  localparam ST_WAIT = 5'h08;
  localparam ST_RUN  = 5'h10;

  reg [1:0]  rstSync_ff;
  wire       rstN;
  wire       pinSync;
  wire       extClkSync;
  reg [4:0]  state_ff;
  reg [4:0]  nxt_state;
  reg [31:0] cnt_ff;
  reg [31:0] lowCnt_ff;
  reg [2:0]  wordCnt_ff;
  reg        cmdSeen_ff;
  reg        cmdReset_ff;
  reg        pinReset;
  reg        extPrev_ff;
  reg [7:0]  divCnt_ff;
  reg        modTick;
  reg [15:0] osrCnt_ff;
  reg [15:0] acc_ff;
  reg [15:0] accFast_ff;
  reg [15:0] pending_ff;
  reg        havePending_ff;
  reg [1:0]  sampleCnt_ff;
  reg [15:0] gcDly_ff;
  wire [16:0] bufOutData;
  wire        bufOutValid;
  wire        bufInReady;
  reg [16:0]  bufInData;
  reg         bufInValid;
  wire        anyReset;

  function [15:0] avgPair;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s       = {1'b0, a} + {1'b0, b};
      avgPair = s[16:1];
    end
  endfunction

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rstSync_ff <= 2'h0;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstN = rstSync_ff[1];

  sync_2ff #(.RESET_VAL(1'b1)) u_pinSync (
    .clk  (ref_clk),
    .rstN (rstN),
    .din  (syncReset_n),
    .dout (pinSync)
  );

  sync_2ff #(.RESET_VAL(1'b0)) u_clkSync (
    .clk  (ref_clk),
    .rstN (rstN),
    .din  (external_clock_in),
    .dout (extClkSync)
  );

  // long low on the pin is reset; shorter pulses are left to sync logic
  always @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      lowCnt_ff <= 32'h0;
    else if (pinSync)
      lowCnt_ff <= 32'h0;
    else if (lowCnt_ff <= RSL_CYCLES)
      lowCnt_ff <= lowCnt_ff + 32'h1;
  end

  always @*
  begin
    pinReset = !pinSync && (lowCnt_ff > RSL_CYCLES);
  end

  // command only counts once all words of its frame arrived
  always @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wordCnt_ff  <= 3'h0;
      cmdSeen_ff  <= 1'b0;
      cmdReset_ff <= 1'b0;
    end
    else
    begin
      cmdReset_ff <= 1'b0;
      if (frameAbort || !spiEnable)
      begin
        wordCnt_ff <= 3'h0;
        cmdSeen_ff <= 1'b0;
      end
      else if (frameWordValid)
      begin
        if (wordCnt_ff == 3'h0)
          cmdSeen_ff <= (frameWord == `CMD_RESET);
        if (wordCnt_ff == (`FRAME_WORDS - 1))
        begin
          wordCnt_ff  <= 3'h0;
          cmdReset_ff <= cmdSeen_ff;
          cmdSeen_ff  <= 1'b0;
        end
        else
          wordCnt_ff <= wordCnt_ff + 3'h1;
      end
    end
  end

  assign anyReset = pinReset || cmdReset_ff;

  // modulator tick: divided reference or external clock edges
  always @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      extPrev_ff <= 1'b0;
      divCnt_ff  <= 8'h00;
    end
    else
    begin
      extPrev_ff <= extClkSync;
      if (divCnt_ff == (`MOD_DIV_DEF - 8'h01))
        divCnt_ff <= 8'h00;
      else
        divCnt_ff <= divCnt_ff + 8'h01;
    end
  end

  always @*
  begin
    if (clockSelInt)
      modTick = (divCnt_ff == 8'h00);
    else
      modTick = extClkSync && !extPrev_ff;
  end

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR:  if (cnt_ff >= POR_CYCLES - 1) nxt_state = ST_CLK;
      ST_RST:  if (!anyReset) nxt_state = ST_CLK;
      ST_CLK:  if (modTick) nxt_state = ST_WAIT;
      ST_WAIT: if (modTick && cnt_ff >= `MOD_WAIT_CYC - 1) nxt_state = ST_RUN;
      ST_RUN:  nxt_state = ST_RUN;
      default: nxt_state = ST_RST;
    endcase
    if (anyReset)
      nxt_state = ST_RST;
  end

  always @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_ff     <= ST_POR;
      cnt_ff       <= 32'h0;
      data_ready_n <= 1'b0;
      spiEnable    <= 1'b0;
      clockSelInt  <= 1'b0;
      powerMode    <= `PWR_DEF;
      modRun       <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff)
        cnt_ff <= 32'h0;
      else if (state_ff == ST_POR || (state_ff == ST_WAIT && modTick))
        cnt_ff <= cnt_ff + 32'h1;
      if (nxt_state == ST_RST || nxt_state == ST_POR)
      begin
        data_ready_n <= 1'b0;
        spiEnable    <= 1'b0;
        clockSelInt  <= 1'b0;
        powerMode    <= `PWR_DEF;
        modRun       <= 1'b0;
      end
      else
      begin
        if (state_ff == ST_POR || state_ff == ST_RST)
        begin
          data_ready_n <= 1'b1;
          spiEnable    <= 1'b1;
        end
        else if (sampleValid)
          data_ready_n <= 1'b0;
        else if (osrCnt_ff == {1'b0, oversampling_ratio[15:1]} && modTick)
          data_ready_n <= 1'b1;
        if (oscEnableSet && spiEnable)
          clockSelInt <= 1'b1;
        if (powerModeWrite && spiEnable && powerModeSet != 2'h3)
          powerMode <= powerModeSet;
        modRun <= (nxt_state == ST_RUN);
      end
    end
  end

  // both paths integrate the same modulator bits
  always @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      osrCnt_ff      <= 16'h0;
      acc_ff         <= 16'h0;
      accFast_ff     <= 16'h0;
      sampleCnt_ff   <= 2'h0;
      fastPathSel    <= 1'b1;
      chopPolarity   <= 1'b0;
      gcDly_ff       <= 16'h0;
      pending_ff     <= 16'h0;
      havePending_ff <= 1'b0;
      bufInData      <= 17'h0;
      bufInValid     <= 1'b0;
    end
    else if (state_ff != ST_RUN)
    begin
      osrCnt_ff      <= 16'h0;
      acc_ff         <= 16'h0;
      accFast_ff     <= 16'h0;
      sampleCnt_ff   <= 2'h0;
      fastPathSel    <= 1'b1;
      chopPolarity   <= 1'b0;
      gcDly_ff       <= 16'h0;
      havePending_ff <= 1'b0;
      bufInValid     <= 1'b0;
    end
    else
    begin
      if (bufInValid && bufInReady)
        bufInValid <= 1'b0;
      if (gcDly_ff != 16'h0)
      begin
        if (modTick)
          gcDly_ff <= gcDly_ff - 16'h1;
      end
      else if (modTick && !(bufInValid && !bufInReady))
      begin
        acc_ff     <= acc_ff + {15'h0, modBit ^ chopPolarity};
        accFast_ff <= accFast_ff + {15'h0, modBit ^ chopPolarity};
        if (osrCnt_ff == oversampling_ratio - 16'h1)
        begin
          osrCnt_ff  <= 16'h0;
          acc_ff     <= 16'h0;
          accFast_ff <= 16'h0;
          if (chop_enable)
          begin
            chopPolarity <= !chopPolarity;
            gcDly_ff     <= chopDelay;
            pending_ff   <= acc_ff;
            havePending_ff <= 1'b1;
            if (havePending_ff)
            begin
              bufInData  <= {1'b0, avgPair(pending_ff, ~acc_ff)};
              bufInValid <= 1'b1;
            end
          end
          else
          begin
            bufInData  <= {fastPathSel, fastPathSel ? accFast_ff : acc_ff};
            bufInValid <= 1'b1;
            if (sampleCnt_ff != `FAST_SAMPLES)
              sampleCnt_ff <= sampleCnt_ff + 2'h1;
            if (sampleCnt_ff == `FAST_SAMPLES - 1)
              fastPathSel <= 1'b0;
          end
        end
        else
          osrCnt_ff <= osrCnt_ff + 16'h1;
      end
    end
  end

  skid_buffer #(.WIDTH(17)) u_buf (
    .clk      (ref_clk),
    .rstN     (rstN),
    .flush    (state_ff != ST_RUN),
    .inData   (bufInData),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .outData  (bufOutData),
    .outValid (bufOutValid),
    .outReady (sampleReady)
  );

  always @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sampleData  <= {SW{1'b0}};
      sampleValid <= 1'b0;
      sampleFast  <= 1'b0;
    end
    else
    begin
      sampleValid <= bufOutValid && sampleReady && (state_ff == ST_RUN);
      if (bufOutValid && sampleReady)
      begin
        sampleData <= bufOutData[SW-1:0];
        sampleFast <= bufOutData[16];
      end
    end
  end
endmodule // adc_reset_startup_sequencer

// ===== hdl/adc_start_regs.vh
// timing counts, field codes and reset defaults for the start-up sequencer
`ifndef ADC_START_REGS_VH
`define ADC_START_REGS_VH
`define CLK_MHZ            100
`define POR_DELAY_US       100
`define POR_DELAY_CYC      (`POR_DELAY_US * `CLK_MHZ)
`define RESET_LOW_WIDTH_NS 2000
`define RESET_LOW_CYC      (`RESET_LOW_WIDTH_NS * `CLK_MHZ / 1000)
`define MOD_WAIT_BASE      256
`define MOD_WAIT_EXTRA     44
`define MOD_WAIT_CYC       (`MOD_WAIT_BASE + `MOD_WAIT_EXTRA)
`define MOD_DIV_DEF        8'h04
`define OSR_DEF            16'h0400
`define FAST_SAMPLES       2
`define SINC3_PERIODS      3
`define FRAME_WORDS        6
`define CMD_RESET          16'h0011
`define PWR_DEF            2'h2
`define GC_DLY_DEF         16'h0010
`define DIV_W              8
`define SAMPLE_W           16
`endif

// ===== hdl/sync_2ff.v
// two flip-flop synchroniser for a pin level
module sync_2ff #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk,
  input  wire rstN,
  input  wire din,
  output reg  dout
);
  reg meta_ff;

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      meta_ff <= RESET_VAL;
      dout    <= RESET_VAL;
    end
    else
    begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule // sync_2ff

// ===== hdl/skid_buffer.v
// two-entry buffer with valid/ready on both sides
module skid_buffer #(
  parameter WIDTH = 17
) (
  input  wire             clk,
  input  wire             rstN,
  input  wire             flush,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem0_ff;
  reg [WIDTH-1:0] mem1_ff;
  reg [1:0]       cnt_ff;
  wire            push;
  wire            pop;

  assign inReady  = (cnt_ff != 2'h2);
  assign outValid = (cnt_ff != 2'h0);
  assign outData  = mem0_ff;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mem0_ff <= {WIDTH{1'b0}};
      mem1_ff <= {WIDTH{1'b0}};
      cnt_ff  <= 2'h0;
    end
    else if (flush)
      cnt_ff <= 2'h0;
    else
    begin
      if (pop)
        mem0_ff <= (cnt_ff == 2'h2) ? mem1_ff : inData;
      if (push && (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop)))
        mem0_ff <= inData;
      if (push && ((cnt_ff == 2'h1 && !pop) || (cnt_ff == 2'h2)))
        mem1_ff <= inData;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // skid_buffer

// ===== verif/host_model.sv
// host-side model: free-running external clock, spi frame words, downstream ready
module host_model (
  input  wire logic        ref_clk,
  input  wire logic        stall,
  output logic             external_clock_in,
  output logic             frameWordValid,
  output logic [15:0]      frameWord,
  output logic             frameAbort,
  output wire logic        sampleReady
);
  timeunit 1ns;
  timeprecision 1ps;
  assign sampleReady = ~stall;
  initial
  begin
    external_clock_in = 1'b0;
    frameWordValid = 1'b0;
    frameWord = 16'h0000;
    frameAbort = 1'b0;
  end
  // four reference cycles per tick, edges aligned to ref_clk falling edges
  always #20 external_clock_in = ~external_clock_in;
  // a count below six words ends the frame with an early deselect
  task automatic send_frame(input logic [15:0] w0, input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(negedge ref_clk);
      frameWordValid = 1'b1;
      frameWord = (i == 0) ? w0 : 16'(i * 16'h1357);
      @(negedge ref_clk);
      frameWordValid = 1'b0;
      frameWord = ~frameWord;
    end
    if (n < 6)
    begin
      frameAbort = 1'b1;
      @(negedge ref_clk);
      frameAbort = 1'b0;
    end
  endtask
endmodule // host_model

// ===== verif/adc_seq_chk.sv
// concurrent checks on the sequencer's ports
module adc_seq_chk #(
  parameter RSL_CYCLES = 20
) (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       syncReset_n,
  input wire logic       external_clock_in,
  input wire logic       oscEnableSet,
  input wire logic [1:0] powerModeSet,
  input wire logic       powerModeWrite,
  input wire logic       sampleReady,
  input wire logic       data_ready_n,
  input wire logic       spiEnable,
  input wire logic       clockSelInt,
  input wire logic [1:0] powerMode,
  input wire logic       fastPathSel,
  input wire logic       modRun,
  input wire logic       chopPolarity,
  input wire logic       sampleValid,
  input wire logic       sampleFast
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] lowCnt;
  logic [9:0]  tickCnt;
  logic [3:0]  accCnt;
  logic        clkD;
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      lowCnt <= 16'h0000;
      tickCnt <= 10'h000;
      accCnt <= 4'h0;
      clkD <= 1'b0;
    end
    else
    begin
      lowCnt <= syncReset_n ? 16'h0000 : lowCnt + 16'h0001;
      clkD <= external_clock_in;
      tickCnt <= !spiEnable ? 10'h000 : tickCnt + {9'h000, external_clock_in & ~clkD & ~modRun};
      accCnt <= !modRun ? 4'h0 : accCnt + {3'h0, sampleValid & sampleReady & (accCnt < 4'h3)};
    end
  AST_READY_LOW: assert property (!spiEnable |-> !data_ready_n) else $error("ready high in reset");
  AST_PIN_RESET: assert property (lowCnt > RSL_CYCLES + 3 |-> !spiEnable) else $error("long pin low no reset");
  AST_DEFAULTS: assert property (!spiEnable [*2] |-> powerMode == 2'h2 && fastPathSel && !modRun)
    else $error("defaults not restored");
  AST_CLK_EXT: assert property (!spiEnable [*2] |-> !clockSelInt) else $error("clock not external");
  AST_OSC_IGNORED: assert property (oscEnableSet && !spiEnable && !clockSelInt |=> !clockSelInt)
    else $error("osc set before ready");
  AST_OSC_SET: assert property (oscEnableSet && spiEnable |=> clockSelInt || !spiEnable)
    else $error("osc select lost");
  AST_MOD_WAIT: assert property ($rose(modRun) && !clockSelInt |-> tickCnt >= 298 && tickCnt <= 303)
    else $error("modulator wait wrong");
  AST_FAST_TWO: assert property (sampleValid |-> sampleFast == (accCnt < 4'h2))
    else $error("filter path wrong");
  AST_PWR_WRITE: assert property (powerModeWrite && spiEnable && powerModeSet != 2'h3
    |=> powerMode == $past(powerModeSet) || !spiEnable) else $error("power mode not taken");
  AST_PWR_KEEP: assert property (powerModeWrite && spiEnable && powerModeSet == 2'h3
    |=> $stable(powerMode) || !spiEnable) else $error("code 3 changed mode");
  COV_RUN: cover property ($rose(modRun));
  COV_SINC: cover property (sampleValid && !sampleFast);
  COV_PIN: cover property (lowCnt == RSL_CYCLES + 4);
  COV_CHOP: cover property ($changed(chopPolarity));
endmodule // adc_seq_chk
bind adc_reset_startup_sequencer adc_seq_chk #(.RSL_CYCLES(RSL_CYCLES)) chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .syncReset_n(syncReset_n), .external_clock_in(external_clock_in), .oscEnableSet(oscEnableSet),
  .powerModeSet(powerModeSet), .powerModeWrite(powerModeWrite), .sampleReady(sampleReady),
  .data_ready_n(data_ready_n), .spiEnable(spiEnable), .clockSelInt(clockSelInt), .powerMode(powerMode),
  .fastPathSel(fastPathSel), .modRun(modRun), .chopPolarity(chopPolarity), .sampleValid(sampleValid),
  .sampleFast(sampleFast));

// ===== verif/testbench.sv
// self-checking bench for the reset and start-up sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OVERSAMPLING_RATIO = 16;
  logic        ref_clk, arst_n, syncReset_n, oscEnableSet, chop_enable, powerModeWrite, modBit, stall;
  logic        extClk, fwValid, fwAbort, smpReady, data_ready_n, spiEnable, clockSelInt, fastPathSel;
  logic        modRun, chopPolarity, sampleValid, sampleFast, drPrev, polPrev;
  logic [15:0] chopDelay, fWord, sampleData;
  logic [1:0]  powerModeSet, powerMode, prevMode;
  int          err_total, comparisons, cycles, lastFall, n, i;
  bit          expQ[$];
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  host_model host (.ref_clk(ref_clk), .stall(stall), .external_clock_in(extClk), .frameWordValid(fwValid),
    .frameWord(fWord), .frameAbort(fwAbort), .sampleReady(smpReady));
  adc_reset_startup_sequencer #(.POR_CYCLES(50), .RSL_CYCLES(20), .SW(16)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .syncReset_n(syncReset_n), .external_clock_in(extClk), .frameWordValid(fwValid),
    .frameWord(fWord), .frameAbort(fwAbort), .oscEnableSet(oscEnableSet), .chop_enable(chop_enable),
    .oversampling_ratio(16'(OVERSAMPLING_RATIO)), .chopDelay(chopDelay), .powerModeSet(powerModeSet),
    .powerModeWrite(powerModeWrite), .modBit(modBit), .sampleReady(smpReady), .data_ready_n(data_ready_n),
    .spiEnable(spiEnable), .clockSelInt(clockSelInt), .powerMode(powerMode), .fastPathSel(fastPathSel),
    .modRun(modRun), .chopPolarity(chopPolarity), .sampleData(sampleData), .sampleValid(sampleValid),
    .sampleFast(sampleFast));
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // notes two fast then two sinc3 results, then stalls so no later sample is taken
  task automatic run_samples;
    int k;
    expQ = {1'b1, 1'b1, 1'b0, 1'b0};
    stall = 1'b0;
    for (k = 0; k < 4000 && expQ.size() > 0; k++) @(negedge ref_clk);
    stall = 1'b1;
    check_val(16'(expQ.size()), 16'h0000, "samples missing");
  endtask
  always @(negedge ref_clk) modBit = 1'($urandom_range(1, 0));
  always @(posedge ref_clk)
  begin
    cycles++;
    if (sampleValid === 1'b1 && smpReady === 1'b1)
    begin
      check_val(16'(sampleData <= 16'(OVERSAMPLING_RATIO)), 16'h0001, "sample range");
      if (expQ.size() == 0)
        check_val(16'h0001, 16'h0000, "unexpected sample");
      else
        check_val(16'(sampleFast), 16'(expQ.pop_front()), "filter path");
    end
    if (modRun !== 1'b1 || chop_enable || stall)
      lastFall = -1;
    else if (data_ready_n === 1'b0 && drPrev === 1'b1)
    begin
      if (lastFall >= 0)
        check_val(16'(cycles - lastFall), 16'(OVERSAMPLING_RATIO * 4), "data rate");
      lastFall = cycles;
    end
    drPrev = data_ready_n;
  end
  // ceiling well above the roughly 5000 cycles the scenarios need
  initial
  begin
    wait (cycles > 20000);
    err_total++;
    give_verdict;
  end
  initial
  begin
    arst_n = 1'b0;
    {syncReset_n, oscEnableSet, chop_enable, powerModeWrite, modBit, stall} = 6'h23;
    {err_total, comparisons, cycles, lastFall, drPrev} = {32'h0, 32'h0, 32'h0, -32'sh1, 1'b0};
    chopDelay = 16'h0004;
    powerModeSet = 2'h0;
    void'($urandom(32'hB6BD));
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    for (n = 0; n < 200 && data_ready_n !== 1'b1; n++) @(negedge ref_clk);
    check_val(16'(n >= 50 && n <= 54), 16'h0001, "power-on delay");
    run_samples;
    oscEnableSet = 1'b1;
    @(negedge ref_clk);
    oscEnableSet = 1'b0;
    check_val(16'(clockSelInt), 16'h0001, "osc select");
    prevMode = powerMode;
    powerModeWrite = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      powerModeSet = 2'(i);
      @(negedge ref_clk);
      prevMode = (i == 3) ? prevMode : 2'(i);
      check_val(16'(powerMode), 16'(prevMode), "power mode");
    end
    powerModeWrite = 1'b0;
    syncReset_n = 1'b0;
    for (n = 0; n < 100 && spiEnable !== 1'b0; n++) @(negedge ref_clk);
    check_val(16'(n >= 21 && n <= 26), 16'h0001, "pin reset width");
    // oscillator request while held in reset must be dropped
    oscEnableSet = 1'b1;
    host.send_frame(16'h0011, 6);
    repeat (30) @(negedge ref_clk);
    oscEnableSet = 1'b0;
    check_val(16'({spiEnable, data_ready_n}), 16'h0000, "pin reset held");
    syncReset_n = 1'b1;
    for (n = 0; n < 20 && spiEnable !== 1'b1; n++) @(negedge ref_clk);
    check_val(16'({spiEnable, clockSelInt, powerMode}), 16'h000A, "state after pin reset");
    repeat (20) @(negedge ref_clk);
    check_val(16'(spiEnable), 16'h0001, "early frame ignored");
    run_samples;
    host.send_frame(16'h0011, 3);
    host.send_frame(16'h0012, 6);
    repeat (10) @(negedge ref_clk);
    check_val(16'(spiEnable), 16'h0001, "cut or foreign frame");
    host.send_frame(16'h0011, 6);
    for (n = 0; n < 10 && spiEnable !== 1'b0; n++) @(negedge ref_clk);
    check_val(16'(n <= 3), 16'h0001, "command reset");
    for (n = 0; n < 20 && spiEnable !== 1'b1; n++) @(negedge ref_clk);
    run_samples;
    chopDelay = 16'($urandom_range(9, 2));
    chop_enable = 1'b1;
    polPrev = chopPolarity;
    for (n = 0; n < 3000 && chopPolarity === polPrev; n++) @(negedge ref_clk);
    check_val(16'(chopPolarity !== polPrev), 16'h0001, "chop swap");
    give_verdict;
  end
endmodule // testbench
